/* hdl/sdram_read_burst.sv */
// Read-burst engine of a synchronous DRAM: decodes read commands from the
// command pins, waits the read latency, then drives strobe and data on both
// link clock edges. Assumes the link clock and command pins come from outside
// the sys_clk domain, and that array data and configuration are on sys_clk.
`timescale 1ns/100ps
`include "sdram_read_consts.svh"

// Behaviour
// - Fixed eight, fixed four, or per-command bursts
// - Per-command mode: chop bit low four, high eight
// - Auto-close bit low: bank stays open
// - Auto-close bit high: bank precharged after burst
// - Field 00 fixed eight, 01 per-command
// - Field 10 fixed four always
// - Data starts at total read latency
// - Release at latency plus four or two
// - Read timing valid only with locked loop
// - One beat on each strobe edge
// - Low preamble before, undriven after burst
module sdram_read_burst (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Link clock and command pins
	input wire logic link_ck,
	input wire logic cs_n,
	input wire logic act_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic auto_close_address_bit,
	input wire logic chop_select_address_bit,
	input wire logic [1:0] bank,
	// Configuration
	input wire logic [1:0] first_mode_register,
	input wire logic [`LATENCY_W-1:0] additive_latency,
	input wire logic [`LATENCY_W-1:0] column_access_latency,
	input wire logic dll_locked,
	// Array side
	input wire logic [`BURST_DATA_W-1:0] array_data,
	output logic read_fetch,
	output logic [1:0] fetch_bank,
	output logic precharge_pulse,
	output logic [1:0] precharge_bank,
	// Data and strobe pins
	output logic [`DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic dqs_out,
	output logic dqs_oe,
	// Status
	output logic read_refused
);

	// ============================================================
	// Pin synchronisers
	logic [`PIN_GROUP_W-1:0] pin_meta;
	logic [`PIN_GROUP_W-1:0] pin_sync;
	logic ck_prev;
	wire [`PIN_GROUP_W-1:0] pin_raw = {link_ck, cs_n, act_n, ras_n, cas_n, we_n,
		auto_close_address_bit, chop_select_address_bit, bank};

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_meta <= '0;
			pin_sync <= '0;
			ck_prev <= 1'b0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			ck_prev <= pin_sync[9];
		end
	end

	wire ck_rise = pin_sync[9] & ~ck_prev;
	wire ck_fall = ~pin_sync[9] & ck_prev;
	wire ck_edge = ck_rise | ck_fall;

	// ============================================================
	// Command decode, taken on the link clock rising edge
	// Any non-read command is ignored here, so it may overlap a burst
	wire is_read = ~pin_sync[8] & pin_sync[7] & pin_sync[6] & ~pin_sync[5]
		& pin_sync[4];
	wire cmd_close = pin_sync[3];
	wire cmd_chop_bit = pin_sync[2];
	wire [1:0] cmd_bank = pin_sync[1:0];
	wire read_take = ck_rise & is_read & dll_locked;
	wire read_bad = ck_rise & is_read & ~dll_locked;

	wire cmd_eight = (first_mode_register == `BURST_CODE_CHOP4) ? 1'b0 :
		(first_mode_register == `BURST_CODE_PERCMD) ? cmd_chop_bit :
		1'b1;
	wire [`CK_COUNT_W-1:0] total_read_latency =
		`CK_COUNT_W'(additive_latency) + `CK_COUNT_W'(column_access_latency);

	// ============================================================
	// Link cycle counter and pending read queue
	logic [`CK_COUNT_W-1:0] ck_count;
	logic [`CK_COUNT_W-1:0] q_due [`QUEUE_DEPTH];
	logic q_eight [`QUEUE_DEPTH];
	logic q_close [`QUEUE_DEPTH];
	logic [1:0] q_bank [`QUEUE_DEPTH];
	logic [`BURST_DATA_W-1:0] q_data [`QUEUE_DEPTH];
	logic [`QUEUE_PTR_W-1:0] wr_ptr;
	logic [`QUEUE_PTR_W-1:0] rd_ptr;
	logic [`QUEUE_PTR_W:0] q_level;

	// Queue full drops the read; the controller's command spacing keeps it clear
	wire q_full = (q_level == (`QUEUE_PTR_W+1)'(`QUEUE_DEPTH));
	wire q_empty = (q_level == '0);
	wire push = read_take & ~q_full;
	wire head_now = ~q_empty & (q_due[rd_ptr] == ck_count);
	wire head_next = ~q_empty & (q_due[rd_ptr] == ck_count + `CK_COUNT_W'(1));

	// ============================================================
	// Output driver state
	sdram_read_pkg::drive_state_type drive_state;
	sdram_read_pkg::drive_state_type next_drive_state;
	logic [3:0] beat;
	logic [3:0] beat_total;
	logic [`BURST_DATA_W-1:0] burst_data;
	logic burst_close;
	logic [1:0] burst_bank;

	wire burst_done = (beat == beat_total);
	wire start_burst = ck_rise & head_now & (drive_state != sdram_read_pkg::drive_burst
		| burst_done);
	wire pop = start_burst;
	wire end_burst = ck_rise & (drive_state == sdram_read_pkg::drive_burst) & burst_done;
	wire next_beat = ck_edge & (drive_state == sdram_read_pkg::drive_burst) & ~burst_done;

	always_comb begin
		next_drive_state = drive_state;
		case (drive_state)
			sdram_read_pkg::drive_idle: begin
				if (start_burst)
					next_drive_state = sdram_read_pkg::drive_burst;
				else if (ck_rise & head_next)
					next_drive_state = sdram_read_pkg::drive_preamble;
			end
			sdram_read_pkg::drive_preamble: begin
				if (start_burst)
					next_drive_state = sdram_read_pkg::drive_burst;
			end
			sdram_read_pkg::drive_burst: begin
				if (start_burst)
					next_drive_state = sdram_read_pkg::drive_burst;
				else if (end_burst & head_next)
					next_drive_state = sdram_read_pkg::drive_preamble;
				else if (end_burst)
					next_drive_state = sdram_read_pkg::drive_idle;
			end
			default: next_drive_state = sdram_read_pkg::drive_idle;
		endcase
	end

	// ============================================================
	// Queue storage and counters
	always_ff @(posedge sys_clk) begin
		if (push) begin
			q_due[wr_ptr] <= ck_count + total_read_latency;
			q_eight[wr_ptr] <= cmd_eight;
			q_close[wr_ptr] <= cmd_close;
			q_bank[wr_ptr] <= cmd_bank;
			q_data[wr_ptr] <= array_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ck_count <= '0;
		end else if (ck_rise) begin
			ck_count <= ck_count + `CK_COUNT_W'(1);
		end
	end

	// ============================================================
	// Queue pointers and fill level
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			q_level <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + `QUEUE_PTR_W'(1);
			if (pop)
				rd_ptr <= rd_ptr + `QUEUE_PTR_W'(1);
			q_level <= q_level + (`QUEUE_PTR_W+1)'(push) - (`QUEUE_PTR_W+1)'(pop);
		end
	end

	// ============================================================
	// Burst driver state
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			drive_state <= sdram_read_pkg::drive_idle;
		end else begin
			drive_state <= next_drive_state;
		end
	end

	// ============================================================
	// Beat counter
	wire [3:0] head_total = q_eight[rd_ptr] ? `EIGHT_BEAT_COUNT : `FOUR_BEAT_COUNT;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			beat <= '0;
			beat_total <= '0;
		end else if (start_burst) begin
			beat <= 4'h1;
			beat_total <= head_total;
		end else if (next_beat) begin
			beat <= beat + 4'h1;
		end
	end

	// ============================================================
	// Burst capture, held so the queue head may move on early
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			burst_data <= '0;
			burst_close <= 1'b0;
			burst_bank <= '0;
		end else if (start_burst) begin
			burst_data <= q_data[rd_ptr];
			burst_close <= q_close[rd_ptr];
			burst_bank <= q_bank[rd_ptr];
		end
	end

	// ============================================================
	// Data and strobe pins
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dq_out <= '0;
			dqs_out <= 1'b0;
		end else if (start_burst) begin
			dq_out <= q_data[rd_ptr][`DATA_W-1:0];
			dqs_out <= 1'b1;
		end else if (next_beat) begin
			dq_out <= burst_data[beat*`DATA_W +: `DATA_W];
			dqs_out <= ~dqs_out;
		end else if (next_drive_state != sdram_read_pkg::drive_burst) begin
			dqs_out <= 1'b0;
		end
	end

	assign dqs_oe = (drive_state != sdram_read_pkg::drive_idle);
	assign dq_oe = (drive_state == sdram_read_pkg::drive_burst);

	// ============================================================
	// Array fetch pulse
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			read_fetch <= 1'b0;
			fetch_bank <= '0;
		end else begin
			read_fetch <= push;
			if (push)
				fetch_bank <= cmd_bank;
		end
	end

	// ============================================================
	// Automatic row close
	wire close_now = end_burst & burst_close;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			precharge_pulse <= 1'b0;
			precharge_bank <= '0;
		end else begin
			// Close the bank only once its last beat is out
			precharge_pulse <= close_now;
			if (close_now)
				precharge_bank <= burst_bank;
		end
	end

	// ============================================================
	// Refusal status
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			read_refused <= 1'b0;
		end else begin
			if (read_bad)
				read_refused <= 1'b1;
			else if (read_take)
				read_refused <= 1'b0;
		end
	end

endmodule : sdram_read_burst

/* pkg/sdram_read_consts.svh */
// Constants for the read-burst engine: mode codes, burst sizes, queue sizes.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef SDRAM_READ_CONSTS_SVH
`define SDRAM_READ_CONSTS_SVH

// ============================================================
// Burst-length field codes
`define BURST_CODE_FIXED8 2'h0
`define BURST_CODE_PERCMD 2'h1
`define BURST_CODE_CHOP4 2'h2

// ============================================================
// Beat counts, one beat per link clock edge
`define EIGHT_BEAT_COUNT 4'h8
`define FOUR_BEAT_COUNT 4'h4

// ============================================================
// Pending read queue, pin group, data and latency widths
`define QUEUE_DEPTH 16
`define QUEUE_PTR_W 4
`define CK_COUNT_W 8
`define PIN_GROUP_W 10
`define DATA_W 8
`define BURST_DATA_W 64
`define LATENCY_W 6
`define LATENCY_RESET 6'h0B

`endif

/* pkg/sdram_read_pkg.sv */
// Types shared by the read-burst engine.
// Assumes the constants header is compiled alongside.
package sdram_read_pkg;

	// ============================================================
	// Output driver state, Gray along idle, preamble, burst
	typedef enum logic [1:0] {
		drive_idle = 2'b00,
		drive_preamble = 2'b01,
		drive_burst = 2'b11
	} drive_state_type;

endpackage : sdram_read_pkg

/* tb/sdram_read_burst_chk.sv */
// Port-timing checker for the read-burst engine.
// Assumes binding to sdram_read_burst; sees only its ports.
`timescale 1ns/100ps
module sdram_read_burst_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Watched ports
	input wire logic dll_locked,
	input wire logic read_fetch,
	input wire logic precharge_pulse,
	input wire logic dq_oe,
	input wire logic dqs_out,
	input wire logic dqs_oe,
	input wire logic read_refused
);
	// ========================================
	// Fetch, refusal, strobe, data and precharge relations
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	sequence s_preamble;
		dqs_oe && !dqs_out && !dq_oe;
	endsequence
	sequence s_release;
		!dqs_oe && !$past(dqs_out);
	endsequence
	a_fetch_when_locked: assert property (read_fetch |-> $past(dll_locked))
		else $error("fetch while loop unlocked");
	a_refuse_no_fetch: assert property ($rose(read_refused) |-> !read_fetch)
		else $error("refused read fetched");
	a_refuse_clears: assert property ($fell(read_refused) |-> read_fetch)
		else $error("refusal cleared without read");
	a_preamble_low: assert property ($rose(dqs_oe) |-> s_preamble)
		else $error("preamble not low");
	a_first_beat: assert property ($rose(dq_oe) |-> dqs_out && $past(dqs_oe))
		else $error("first beat not on rising strobe");
	a_data_framed: assert property (dq_oe |-> dqs_oe)
		else $error("data driven without strobe");
	a_burst_holds: assert property ($rose(dq_oe) |-> dq_oe [*8])
		else $error("burst released early");
	a_release_low: assert property ($fell(dq_oe) |-> s_release)
		else $error("strobe not released after burst");
	a_precharge_once: assert property (precharge_pulse |-> !dq_oe ##1 !precharge_pulse)
		else $error("precharge pulse wrong");
endmodule : sdram_read_burst_chk

bind sdram_read_burst sdram_read_burst_chk chk (.sys_clk(sys_clk), .srst(srst),
	.dll_locked(dll_locked), .read_fetch(read_fetch), .precharge_pulse(precharge_pulse),
	.dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .read_refused(read_refused));

/* tb/ctrl_model.sv */
// Memory controller model: free-running link clock and read commands.
// Assumes the engine synchronises these pins to its own clock.
`timescale 1ns/100ps
module ctrl_model (
	// Link clock and command pins
	output logic link_ck,
	output logic cs_n,
	output logic cas_n,
	output logic close_bit,
	output logic chop_bit,
	output logic [1:0] bank
);
	// ========================================
	// Clock and command issue
	int rises = 0;
	initial link_ck = 1'b0;
	initial cs_n = 1'b1;
	initial cas_n = 1'b1;
	initial close_bit = 1'b0;
	initial chop_bit = 1'b0;
	initial bank = 2'h0;
	always #62.5 link_ck = ~link_ck;
	always @(posedge link_ck) rises <= rises + 1;
	// Pins move on the falling edge so they are settled at each rise
	task automatic issue(input logic close, input logic chop, output int n);
		@(negedge link_ck);
		cs_n <= 1'b0;
		cas_n <= 1'b0;
		close_bit <= close;
		chop_bit <= chop;
		bank <= 2'h2;
		@(posedge link_ck);
		#1 n = rises;
		@(negedge link_ck);
		// A non-read command while the burst is pending
		cas_n <= 1'b1;
		// Address lines of the non-read command do not keep their last value
		close_bit <= ~close;
		chop_bit <= ~chop;
		bank <= 2'h1;
		@(negedge link_ck);
		cs_n <= 1'b1;
	endtask : issue
endmodule : ctrl_model

/* tb/tb.sv */
// Self-checking bench for the read-burst engine.
// Assumes ctrl_model on the link side and the bound checker.
`timescale 1ns/100ps
module tb;
	// ========================================
	// Signals and instances
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [5:0] al = 6'h00;
	logic [5:0] cl = 6'h06;
	logic dll = 1'b1;
	logic [63:0] data = 64'h0123_4567_89ab_cdef;
	logic link_ck, cs_n, cas_n, close_bit, chop_bit, read_fetch, pre_p, dq_oe, dqs_out;
	logic dqs_oe, refused;
	logic [1:0] bank, fetch_bank, pre_bank;
	logic [7:0] dq_out;
	int bad_count = 0;
	int comparisons = 0;
	always #4 sys_clk = ~sys_clk;
	ctrl_model p (.link_ck(link_ck), .cs_n(cs_n), .cas_n(cas_n), .close_bit(close_bit),
		.chop_bit(chop_bit), .bank(bank));
	sdram_read_burst dut (.sys_clk(sys_clk), .srst(srst), .link_ck(link_ck), .cs_n(cs_n),
		.act_n(1'b1), .ras_n(1'b1), .cas_n(cas_n), .we_n(1'b1),
		.auto_close_address_bit(close_bit), .chop_select_address_bit(chop_bit), .bank(bank),
		.first_mode_register(mode), .additive_latency(al), .column_access_latency(cl),
		.dll_locked(dll), .array_data(data), .read_fetch(read_fetch), .fetch_bank(fetch_bank),
		.precharge_pulse(pre_p), .precharge_bank(pre_bank), .dq_out(dq_out), .dq_oe(dq_oe),
		.dqs_out(dqs_out), .dqs_oe(dqs_oe), .read_refused(refused));
	// ========================================
	// Shared tasks
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic finish_test;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask : tick
	// Beats are picked up at each strobe change while data is driven
	task automatic do_read(input logic close, input logic chop, input int beats);
		int n;
		int k;
		int t;
		logic last;
		logic pre;
		k = 0;
		t = 0;
		pre = 1'b0;
		p.issue(close, chop, n);
		while (dq_oe !== 1'b1 && t < 1000) begin
			tick();
			t++;
		end
		check("start", 8'(p.rises - n), 8'(al + cl));
		check("bank", {6'h0, fetch_bank}, 8'h02);
		last = ~dqs_out;
		while (dq_oe === 1'b1 && t < 2000) begin
			if (dqs_out !== last) begin
				check("beat", dq_out, data[8*k +: 8]);
				k++;
			end
			last = dqs_out;
			tick();
			t++;
		end
		check("stop", 8'(p.rises - n), 8'(al + cl + beats / 2));
		check("beats", 8'(k), 8'(beats));
		// The close pulse rises with the data release, so look before ticking
		repeat (3) begin
			pre |= pre_p;
			tick();
		end
		check("close", {7'h0, pre}, {7'h0, close});
		if (close) check("close bank", {6'h0, pre_bank}, 8'h02);
	endtask : do_read
	// ========================================
	// Scenarios
	task automatic s_fixed;
		do_read(1'b0, 1'b0, 8);
		@(posedge sys_clk) mode <= 2'h2;
		do_read(1'b1, 1'b1, 4);
	endtask : s_fixed
	task automatic s_per_command;
		@(posedge sys_clk) mode <= 2'h1;
		do_read(1'b0, 1'b0, 4);
		do_read(1'b1, 1'b1, 8);
	endtask : s_per_command
	task automatic s_latency;
		@(posedge sys_clk) al <= 6'h03;
		cl <= 6'h05;
		do_read(1'b0, 1'b1, 8);
		@(posedge sys_clk) mode <= 2'h3;
		do_read(1'b0, 1'b0, 8);
	endtask : s_latency
	task automatic s_unlocked;
		int n;
		@(posedge sys_clk) dll <= 1'b0;
		p.issue(1'b0, 1'b1, n);
		repeat (150) tick();
		check("refused", {7'h0, refused}, 8'h01);
		check("no data", {7'h0, dqs_oe}, 8'h00);
		@(posedge sys_clk) dll <= 1'b1;
		do_read(1'b1, 1'b1, 8);
		check("refusal cleared", {7'h0, refused}, 8'h00);
	endtask : s_unlocked
	initial begin
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (4) tick();
		s_fixed();
		s_per_command();
		s_latency();
		s_unlocked();
		finish_test();
	end
	initial begin
		#200000;
		bad_count++;
		finish_test();
	end
endmodule : tb
